//--- verilog/pwm_core.sv
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Function
// - four 8-bit channels, or pairs joined into 16-bit channels.
// - each channel has period, duty, own counter; duty 0 to full on.
// - each channel is left-aligned or center-aligned.
// - while enabled, new period or duty waits for rollover or disable.
// - while disabled, writes reach buffer and active value together.
// - counter write clears the counter and loads pending period and duty.
// - software can read each channel counter.
// - enabled channel owns its port pin; unused pins stay general I/O.
// - upper join: ch2 high byte, ch3 low, pin 2, ch3 clock, pin 3 free.
// - lower join: ch0 high byte, ch1 low, pin 0, ch1 clock, pin 1 free.
// - clock a serves channels 0 and 1, clock b channels 2 and 3.
// - prescale field divides module clock by two to its value.
// - channels 2 and 3 pick clock b or scaled clock b.
// - channel 1 picks clock a or scaled clock a.
// - scaled clock b is clock b divided by even factor 2 to 512.
// - control and clock select registers are read and write any time.
// - channel 0 picks clock a or scaled clock a.
// - scaled clock b divides by scale value plus one, then two.
// - enable forces pin to output without changing its direction bit.
module pwm_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // general-purpose port side
  input wire logic [3:0] port_dout,
  input wire logic [3:0] port_dir,
  // pins
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);
  // ==========================================
  // bus slave
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;
  logic [7:0] wi;
  logic [7:0] ri;
  logic w_in_range;
  logic r_in_range;
  logic wr_hit;
  logic we;
  logic rd_hit;
  logic [7:0] rd_byte;

  // handshakes
  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;
  assign ar_take = s_axi_arvalid && arready_q;

  // address and data hold, either may come first
  always_ff @(posedge ref_clk) begin
    if (aw_take) awaddr_q <= s_axi_awaddr;
    if (w_take) wdata_q <= s_axi_wdata;
    if (w_take) wstrb_q <= s_axi_wstrb;
  end

  // write channel flow
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= pwm_pkg::RESP_OKAY;
    end else begin
      if (aw_take) awready_q <= 1'b0;
      if (w_take) wready_q <= 1'b0;
      if (wr_fire) bvalid_q <= 1'b1;
      if (wr_fire) bresp_q <= wr_hit ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read channel flow
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= pwm_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
      rdata_q <= {24'h00_0000, rd_hit ? rd_byte : 8'h00};
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ==========================================
  // register file
  logic [7:0] ctrl_q;
  logic [7:0] pol_q;
  logic [3:0] en_q;
  logic [3:0] align_q;
  logic [7:0] scale_a_q;
  logic [7:0] scale_b_q;
  logic [7:0] cnt_q [4];
  logic [7:0] per_buf_q [4];
  logic [7:0] duty_buf_q [4];
  logic [7:0] per_act_q [4];
  logic [7:0] duty_act_q [4];
  logic [3:0] down_q;
  logic [3:0] cnt_wr;
  logic [3:0] per_wr;
  logic [3:0] duty_wr;
  logic join_upper_pair;
  logic join_lower_pair;

  // address decode, byte lane 0 carries every register
  assign wi = awaddr_q[9:2];
  assign ri = s_axi_araddr[9:2];
  assign w_in_range = (awaddr_q[31:10] == 22'h00_0000);
  assign r_in_range = (s_axi_araddr[31:10] == 22'h00_0000);
  assign wr_hit = w_in_range && (wi == pwm_pkg::IDX_CTRL || wi == pwm_pkg::IDX_POL
    || wi == pwm_pkg::IDX_EN || wi == pwm_pkg::IDX_ALIGN || wi == pwm_pkg::IDX_SCALE_A
    || wi == pwm_pkg::IDX_SCALE_B || wi[7:2] == pwm_pkg::IDX_CNT0[7:2]
    || wi[7:2] == pwm_pkg::IDX_PER0[7:2] || wi[7:2] == pwm_pkg::IDX_DUTY0[7:2]);
  assign we = wr_fire && wr_hit && wstrb_q[0];
  assign rd_byte = (ri == pwm_pkg::IDX_CTRL) ? ctrl_q
    : (ri == pwm_pkg::IDX_POL) ? pol_q
    : (ri == pwm_pkg::IDX_EN) ? {4'h0, en_q}
    : (ri == pwm_pkg::IDX_ALIGN) ? {4'h0, align_q}
    : (ri == pwm_pkg::IDX_SCALE_A) ? scale_a_q
    : (ri == pwm_pkg::IDX_SCALE_B) ? scale_b_q
    : (ri[7:2] == pwm_pkg::IDX_CNT0[7:2]) ? cnt_q[ri[1:0]]
    : (ri[7:2] == pwm_pkg::IDX_PER0[7:2]) ? per_buf_q[ri[1:0]]
    : duty_buf_q[ri[1:0]];
  assign rd_hit = r_in_range && (ri == pwm_pkg::IDX_CTRL || ri == pwm_pkg::IDX_POL
    || ri == pwm_pkg::IDX_EN || ri == pwm_pkg::IDX_ALIGN || ri == pwm_pkg::IDX_SCALE_A
    || ri == pwm_pkg::IDX_SCALE_B || ri[7:2] == pwm_pkg::IDX_CNT0[7:2]
    || ri[7:2] == pwm_pkg::IDX_PER0[7:2] || ri[7:2] == pwm_pkg::IDX_DUTY0[7:2]);

  // control registers, writable at any time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= pwm_pkg::CTRL_RST;
      pol_q <= pwm_pkg::POL_RST;
      en_q <= 4'h0;
      align_q <= 4'h0;
      scale_a_q <= pwm_pkg::SCALE_RST;
      scale_b_q <= pwm_pkg::SCALE_RST;
    end else if (we) begin
      if (wi == pwm_pkg::IDX_CTRL) ctrl_q <= wdata_q[7:0];
      if (wi == pwm_pkg::IDX_POL) pol_q <= wdata_q[7:0];
      if (wi == pwm_pkg::IDX_EN) en_q <= wdata_q[3:0];
      if (wi == pwm_pkg::IDX_ALIGN) align_q <= wdata_q[3:0];
      if (wi == pwm_pkg::IDX_SCALE_A) scale_a_q <= wdata_q[7:0];
      if (wi == pwm_pkg::IDX_SCALE_B) scale_b_q <= wdata_q[7:0];
    end
  end

  assign join_upper_pair = ctrl_q[pwm_pkg::CTRL_JOIN_UPPER];
  assign join_lower_pair = ctrl_q[pwm_pkg::CTRL_JOIN_LOWER];

  // ==========================================
  // clock tree
  pwm_pkg::clk_cfg_t clk_cfg;
  logic [3:0] ch_tick;

  assign clk_cfg.a_sel = ctrl_q[pwm_pkg::CTRL_PCKA_LSB +: 3];
  assign clk_cfg.b_sel = ctrl_q[pwm_pkg::CTRL_PCKB_LSB +: 3];
  assign clk_cfg.a_scale = scale_a_q;
  assign clk_cfg.b_scale = scale_b_q;
  assign clk_cfg.a_load = we && (wi == pwm_pkg::IDX_SCALE_A);
  assign clk_cfg.b_load = we && (wi == pwm_pkg::IDX_SCALE_B);
  assign clk_cfg.use_scaled = pol_q[pwm_pkg::POL_CLK_LSB +: 4];
  assign clk_cfg.run = |en_q;

  pwm_clock_tree u_clock_tree (
    .ref_clk(ref_clk),
    .rst(rst),
    .cfg(clk_cfg),
    .ch_tick(ch_tick)
  );

  // ==========================================
  // waveform engines
  logic [3:0] run;
  logic [3:0] roll;
  logic [3:0] clr;
  logic [3:0] active;
  logic [3:0] own;
  logic [3:0] wave;
  logic [3:0] dn_n;
  logic [3:0] ld;
  logic [7:0] cnt_n [4];
  pwm_pkg::pin_drive_t pin_q;

  // one counter step: {rollover, next direction, next count}
  function automatic logic [17:0] step(input logic [15:0] c, input logic [15:0] p,
                                       input logic dn, input logic ctr);
    logic r;
    logic d;
    logic [15:0] n;
    r = 1'b0;
    d = dn;
    n = c;
    if (!ctr) begin
      d = 1'b0;
      if (p == 16'h0000 || c >= p - 16'h0001) begin
        r = 1'b1;
        n = 16'h0000;
      end else n = c + 16'h0001;
    end else if (!dn) begin
      if (c >= p) begin
        if (p == 16'h0000) r = 1'b1;
        else d = 1'b1;
        n = (p == 16'h0000) ? 16'h0000 : c - 16'h0001;
      end else n = c + 16'h0001;
    end else if (c == 16'h0000) begin
      r = 1'b1;
      d = 1'b0;
      n = (p == 16'h0000) ? 16'h0000 : 16'h0001;
    end else n = c - 16'h0001;
    return {r, d, n};
  endfunction : step

  // per pair: separate 8-bit lanes or one joined 16-bit lane
  for (genvar pr = 0; pr < 2; pr++) begin : g_pair
    localparam int H = 2 * pr;
    localparam int L = 2 * pr + 1;
    logic jn;
    logic [15:0] c16;
    logic [15:0] d16;
    logic [17:0] s16;
    logic [17:0] sh;
    logic [17:0] sl;
    assign jn = (pr == 0) ? join_lower_pair : join_upper_pair;
    assign c16 = {cnt_q[H], cnt_q[L]};
    assign d16 = {duty_act_q[H], duty_act_q[L]};
    assign s16 = step(c16, {per_act_q[H], per_act_q[L]}, down_q[H], align_q[H]);
    assign sh = step({8'h00, cnt_q[H]}, {8'h00, per_act_q[H]}, down_q[H], align_q[H]);
    assign sl = step({8'h00, cnt_q[L]}, {8'h00, per_act_q[L]}, down_q[L], align_q[L]);
    // joined lane uses low channel clock and high channel pin
    assign run[H] = en_q[H] && (jn ? ch_tick[L] : ch_tick[H]);
    assign run[L] = jn ? run[H] : en_q[L] && ch_tick[L];
    assign roll[H] = jn ? s16[17] : sh[17];
    assign roll[L] = jn ? s16[17] : sl[17];
    assign dn_n[H] = jn ? s16[16] : sh[16];
    assign dn_n[L] = jn ? s16[16] : sl[16];
    assign cnt_n[H] = jn ? s16[15:8] : sh[7:0];
    assign cnt_n[L] = jn ? s16[7:0] : sl[7:0];
    assign clr[H] = cnt_wr[H] || (jn && cnt_wr[L]);
    assign clr[L] = cnt_wr[L] || (jn && cnt_wr[H]);
    assign active[H] = en_q[H];
    assign active[L] = jn ? en_q[H] : en_q[L];
    assign own[H] = en_q[H];
    assign own[L] = en_q[L] && !jn;
    // output level from count against duty, polarity flips it
    assign wave[H] = (jn ? (c16 < d16) : (cnt_q[H] < duty_act_q[H]))
      ? pol_q[pwm_pkg::POL_POL_LSB + H] : ~pol_q[pwm_pkg::POL_POL_LSB + H];
    assign wave[L] = (cnt_q[L] < duty_act_q[L])
      ? pol_q[pwm_pkg::POL_POL_LSB + L] : ~pol_q[pwm_pkg::POL_POL_LSB + L];
  end

  // per channel: double-buffered period and duty, counter
  for (genvar i = 0; i < pwm_pkg::NCH; i++) begin : g_ch
    logic [7:0] per_d;
    logic [7:0] duty_d;
    assign cnt_wr[i] = we && wi[7:2] == pwm_pkg::IDX_CNT0[7:2] && wi[1:0] == 2'(i);
    assign per_wr[i] = we && wi[7:2] == pwm_pkg::IDX_PER0[7:2] && wi[1:0] == 2'(i);
    assign duty_wr[i] = we && wi[7:2] == pwm_pkg::IDX_DUTY0[7:2] && wi[1:0] == 2'(i);
    assign ld[i] = !active[i] || (run[i] && roll[i]) || clr[i];
    assign per_d = per_wr[i] ? wdata_q[7:0] : per_buf_q[i];
    assign duty_d = duty_wr[i] ? wdata_q[7:0] : duty_buf_q[i];
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        per_buf_q[i] <= pwm_pkg::PER_RST;
        duty_buf_q[i] <= pwm_pkg::DUTY_RST;
        per_act_q[i] <= pwm_pkg::PER_RST;
        duty_act_q[i] <= pwm_pkg::DUTY_RST;
      end else begin
        if (per_wr[i]) per_buf_q[i] <= wdata_q[7:0];
        if (duty_wr[i]) duty_buf_q[i] <= wdata_q[7:0];
        if (ld[i]) per_act_q[i] <= per_d;
        if (ld[i]) duty_act_q[i] <= duty_d;
      end
    end
    // counter holds while disabled, cleared by a write
    always_ff @(posedge ref_clk) begin
      if (rst || clr[i]) begin
        cnt_q[i] <= pwm_pkg::CNT_RST;
        down_q[i] <= 1'b0;
      end else if (run[i]) begin
        cnt_q[i] <= cnt_n[i];
        down_q[i] <= dn_n[i];
      end
    end
  end

  // pin drive: enabled channel takes pin, direction bit untouched
  always_ff @(posedge ref_clk) begin
    if (rst) pin_q <= '0;
    else begin
      pin_q.oe <= own | port_dir;
      pin_q.dout <= (own & wave) | (~own & port_dout);
    end
  end

  // ==========================================
  // outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign pin_out = pin_q.dout;
  assign pin_oe = pin_q.oe;

  // ==========================================
  // checks
  AST_PIN_TAKEOVER: assert property (@(posedge ref_clk) disable iff (rst)
    en_q[0] |=> pin_q.oe[0]) else $error("enabled channel 0 pin not driven");
  AST_JOIN_LOW_FREE: assert property (@(posedge ref_clk) disable iff (rst)
    join_lower_pair |=> pin_q.oe[1] == $past(port_dir[1]) && pin_q.dout[1] == $past(port_dout[1]))
    else $error("joined channel 1 pin not general I/O");
  AST_JOIN_UP_FREE: assert property (@(posedge ref_clk) disable iff (rst)
    join_upper_pair |=> pin_q.oe[3] == $past(port_dir[3]))
    else $error("joined channel 3 pin not general I/O");
  AST_CNT_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
    cnt_wr[0] |=> cnt_q[0] == 8'h00 && per_act_q[0] == $past(per_buf_q[0]))
    else $error("counter write did not clear and load");
  AST_DIRECT_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
    per_wr[2] && !active[2] |=> per_act_q[2] == $past(wdata_q[7:0]))
    else $error("disabled period write not direct");
  AST_BUFFER_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    duty_wr[0] && active[0] && !ld[0] |=> $stable(duty_act_q[0]))
    else $error("enabled duty write applied early");
  AST_CNT_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    !run[1] && !clr[1] |=> $stable(cnt_q[1])) else $error("counter moved without tick");
  AST_LEFT_WRAP: assert property (@(posedge ref_clk) disable iff (rst)
    run[0] && !clr[0] && !join_lower_pair && !align_q[0] && per_act_q[0] != 8'h00
    && cnt_q[0] == per_act_q[0] - 8'h01 |=> cnt_q[0] == 8'h00)
    else $error("left-aligned counter did not wrap at period");
  AST_CTRL_RESET: assert property (@(posedge ref_clk)
    rst |=> ctrl_q == pwm_pkg::CTRL_RST && pol_q == pwm_pkg::POL_RST)
    else $error("control not cleared by reset");
  AST_CTRL_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    we && wi == pwm_pkg::IDX_CTRL |=> ctrl_q == $past(wdata_q[7:0]))
    else $error("control write lost");
  AST_READ_CNT: assert property (@(posedge ref_clk) disable iff (rst)
    ar_take && r_in_range && ri == pwm_pkg::IDX_CNT0 |=> rdata_q[7:0] == $past(cnt_q[0]))
    else $error("counter read wrong");
  COV_JOINED_RUN: cover property (@(posedge ref_clk) disable iff (rst)
    join_lower_pair && run[0] && roll[0]);
  COV_CENTER_ROLL: cover property (@(posedge ref_clk) disable iff (rst)
    align_q[2] && run[2] && roll[2]);
  COV_WRITE_DONE: cover property (@(posedge ref_clk) disable iff (rst)
    bvalid_q && s_axi_bready);
endmodule : pwm_core

//--- verilog/pwm_pkg.sv
// ==========================================
// pwm constants and carriers
package pwm_pkg;
  localparam int NCH = 4;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_POL = 8'h41;
  localparam logic [7:0] IDX_EN = 8'h42;
  localparam logic [7:0] IDX_ALIGN = 8'h43;
  localparam logic [7:0] IDX_SCALE_A = 8'h44;
  localparam logic [7:0] IDX_SCALE_B = 8'h46;
  localparam logic [7:0] IDX_CNT0 = 8'h48;
  localparam logic [7:0] IDX_PER0 = 8'h4C;
  localparam logic [7:0] IDX_DUTY0 = 8'h50;
  // control register fields
  localparam int CTRL_JOIN_UPPER = 7;
  localparam int CTRL_JOIN_LOWER = 6;
  localparam int CTRL_PCKB_LSB = 3;
  localparam int CTRL_PCKA_LSB = 0;
  // clock select and polarity fields
  localparam int POL_CLK_LSB = 4;
  localparam int POL_POL_LSB = 0;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] POL_RST = 8'h00;
  localparam logic [7:0] PER_RST = 8'hFF;
  localparam logic [7:0] DUTY_RST = 8'hFF;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] SCALE_RST = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] dout;
  } pin_drive_t;

  typedef struct packed {
    logic [2:0] a_sel;
    logic [2:0] b_sel;
    logic [7:0] a_scale;
    logic [7:0] b_scale;
    logic a_load;
    logic b_load;
    logic [3:0] use_scaled;
    logic run;
  } clk_cfg_t;
endpackage : pwm_pkg

//--- verilog/pwm_clock_tree.sv
`timescale 1ns/10ps
// ==========================================
// prescaler, scalers and per-channel clock ticks
module pwm_clock_tree (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // configuration
  input pwm_pkg::clk_cfg_t cfg,
  // one tick per channel clock edge
  output logic [3:0] ch_tick
);
  logic [6:0] pre_q;
  logic [7:0] mask_a;
  logic [7:0] mask_b;
  logic tick_a;
  logic tick_b;
  logic [1:0] base;
  logic [1:0] s_tick;
  logic [7:0] sc_q [2];
  logic [1:0] half_q;

  // free prescaler on the module clock, held at zero when no channel runs
  always_ff @(posedge ref_clk) begin
    if (rst || !cfg.run) pre_q <= 7'h00;
    else pre_q <= pre_q + 7'h01;
  end

  // clock a and b are the module clock divided by two to the field
  assign mask_a = (8'h01 << cfg.a_sel) - 8'h01;
  assign mask_b = (8'h01 << cfg.b_sel) - 8'h01;
  assign tick_a = cfg.run && ((pre_q & mask_a[6:0]) == mask_a[6:0]);
  assign tick_b = cfg.run && ((pre_q & mask_b[6:0]) == mask_b[6:0]);
  assign base = {tick_b, tick_a};

  // scalers: divide by value plus one, then by two
  for (genvar k = 0; k < 2; k++) begin : g_scale
    logic [7:0] scale;
    logic load;
    assign scale = (k == 0) ? cfg.a_scale : cfg.b_scale;
    assign load = (k == 0) ? cfg.a_load : cfg.b_load;
    assign s_tick[k] = base[k] && (sc_q[k] == 8'h00) && half_q[k];
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        sc_q[k] <= 8'h00;
        half_q[k] <= 1'b0;
      end else if (load) begin
        sc_q[k] <= scale;
        half_q[k] <= 1'b0;
      end else if (base[k]) begin
        sc_q[k] <= (sc_q[k] == 8'h00) ? scale : sc_q[k] - 8'h01;
        half_q[k] <= (sc_q[k] == 8'h00) ? ~half_q[k] : half_q[k];
      end
    end
  end

  // channel clock choice: a or scaled a low, b or scaled b high
  assign ch_tick[0] = cfg.use_scaled[0] ? s_tick[0] : tick_a;
  assign ch_tick[1] = cfg.use_scaled[1] ? s_tick[0] : tick_a;
  assign ch_tick[2] = cfg.use_scaled[2] ? s_tick[1] : tick_b;
  assign ch_tick[3] = cfg.use_scaled[3] ? s_tick[1] : tick_b;

  // checks
  AST_PRESC_UNDIV: assert property (@(posedge ref_clk) disable iff (rst)
    cfg.run && cfg.a_sel == 3'h0 |-> tick_a) else $error("undivided clock a missing");
  AST_PRESC_DIV2: assert property (@(posedge ref_clk) disable iff (rst)
    tick_a && cfg.a_sel == 3'h1 && $stable(cfg.a_sel) |=> !tick_a)
    else $error("clock a divide by two wrong");
  AST_SCALED_B: assert property (@(posedge ref_clk) disable iff (rst)
    s_tick[1] |-> tick_b) else $error("scaled b tick without b tick");
  AST_SCALE_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
    tick_b && sc_q[1] == 8'h00 && !cfg.b_load |=> sc_q[1] == $past(cfg.b_scale))
    else $error("scale b counter did not reload");
endmodule : pwm_clock_tree

//--- verif/pwm_core_tb_top.sv
`timescale 1ns/10ps
// ==========================================
// register bus, pin and waveform bench
module pwm_core_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [2:0] prot = 3'h0;
  logic [3:0] strb = 4'hF, dout = 4'h0, dir = 4'h0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, got;
  logic [3:0] pout, poe;
  logic [7:0] rc, rp;
  int n_errors = 0;
  int cmp_count = 0;
  localparam logic [1:0] OK = pwm_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pwm_pkg::RESP_SLVERR;
  // clock tree scenario settings
  localparam int SEL_A = 1;
  localparam int SEL_B = 2;
  localparam int SCL_A = 1;
  localparam int SCL_B = 0;
  localparam int RUN_EDGES = 100;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  pwm_core u_pwm_core (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awprot(prot), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .port_dout(dout), .port_dir(dir),
    .pin_out(pout), .pin_oe(poe));

  // ==========================================
  // reporting
  task finish_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task check_val(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : check_val

  // expected pin drive: owned pins carry the waveform, others the port
  function automatic logic [31:0] pin_exp(input logic [3:0] own, input logic [3:0] wave);
    return 32'({own | dir, (own & wave) | (~own & dout)});
  endfunction : pin_exp

  // expected count after the clock tree run: edges over 2^sel, scaled over 2*(scale+1)
  function automatic logic [31:0] cnt_exp(input int ch);
    int a;
    a = RUN_EDGES >> ((ch < 2) ? SEL_A : SEL_B);
    if (ch % 2 == 1) a = a / (2 * (((ch < 2) ? SCL_A : SCL_B) + 1));
    return 32'(a);
  endfunction : cnt_exp

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // ==========================================
  // axi4-lite master, address and data offered together
  task axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic pa, pw;
    int t;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= {22'h00_0000, idx, 2'b00};
    wdata <= {24'h00_0000, d};
    prot <= 3'($urandom);
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge ref_clk);
      if (pa && awr) begin
        pa = 1'b0;
        awv <= 1'b0;
      end
      if (pw && wr) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
      if (bv === 1'b1) break;
    end
    br <= 1'b0;
    if (t == 50) begin
      n_errors++;
      finish_test();
    end
    check_val(32'(bresp), 32'(er));
    @(posedge ref_clk);
  endtask : axi_wr

  task axi_rd(input logic [7:0] idx, input logic [1:0] er);
    int t;
    araddr <= {22'h00_0000, idx, 2'b00};
    arv <= 1'b1;
    rr <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge ref_clk);
      if (arv && arr) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    got = rdata;
    rr <= 1'b0;
    if (t == 50) begin
      n_errors++;
      finish_test();
    end
    check_val(32'(rresp), 32'(er));
    @(posedge ref_clk);
  endtask : axi_rd

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h9ce8_0415));
    tick(8);
    rst <= 1'b0;
    @(posedge ref_clk);
    // values after reset
    axi_rd(pwm_pkg::IDX_CTRL, OK);
    check_val(got, 32'(pwm_pkg::CTRL_RST));
    axi_rd(pwm_pkg::IDX_POL, OK);
    check_val(got, 32'(pwm_pkg::POL_RST));
    axi_rd(pwm_pkg::IDX_PER0 + 8'h02, OK);
    check_val(got, 32'(pwm_pkg::PER_RST));
    // random read back of control and clock select
    for (int i = 0; i < 4; i++) begin
      rc = 8'($urandom);
      rp = 8'($urandom);
      axi_wr(pwm_pkg::IDX_CTRL, rc, OK);
      axi_wr(pwm_pkg::IDX_POL, rp, OK);
      axi_rd(pwm_pkg::IDX_CTRL, OK);
      check_val(got, 32'(rc));
      axi_rd(pwm_pkg::IDX_POL, OK);
      check_val(got, 32'(rp));
    end
    // low strobe clear leaves the register alone
    strb <= 4'hE;
    axi_wr(pwm_pkg::IDX_CTRL, ~rc, OK);
    strb <= 4'hF;
    axi_rd(pwm_pkg::IDX_CTRL, OK);
    check_val(got, 32'(rc));
    // unmapped places
    axi_wr(8'h45, 8'h12, ERR);
    axi_rd(8'h47, ERR);
    check_val(got, 32'h0000_0000);
    axi_wr(pwm_pkg::IDX_CTRL, 8'h00, OK);
    axi_wr(pwm_pkg::IDX_POL, 8'h01, OK);
    // idle pins follow the port
    dout <= 4'($urandom);
    dir <= 4'($urandom) & 4'hA;
    tick(3);
    check_val(32'({poe, pout}), pin_exp(4'h0, 4'h0));
    // channel 0 full on, loaded while disabled
    axi_wr(pwm_pkg::IDX_PER0, 8'h04, OK);
    axi_wr(pwm_pkg::IDX_DUTY0, 8'hFF, OK);
    axi_wr(pwm_pkg::IDX_EN, 8'h01, OK);
    tick(4);
    check_val(32'({poe, pout}), pin_exp(4'h1, 4'h1));
    // duty zero while running takes effect after rollover
    axi_wr(pwm_pkg::IDX_DUTY0, 8'h00, OK);
    axi_rd(pwm_pkg::IDX_DUTY0, OK);
    check_val(got, 32'h0000_0000);
    tick(12);
    check_val(32'({poe, pout}), pin_exp(4'h1, 4'h0));
    // center aligned full on
    axi_wr(pwm_pkg::IDX_ALIGN, 8'h01, OK);
    axi_wr(pwm_pkg::IDX_DUTY0, 8'hFF, OK);
    tick(20);
    check_val(32'({poe, pout}), pin_exp(4'h1, 4'h1));
    // lower join frees pin 1
    axi_wr(pwm_pkg::IDX_CTRL, 8'h40, OK);
    axi_wr(pwm_pkg::IDX_EN, 8'h03, OK);
    tick(4);
    check_val(32'({poe, pout}), pin_exp(4'h1, 4'h1));
    // upper join frees pin 3, low polarity
    axi_wr(pwm_pkg::IDX_CTRL, 8'h80, OK);
    axi_wr(pwm_pkg::IDX_EN, 8'h0C, OK);
    tick(4);
    check_val(32'({poe, pout}), pin_exp(4'h4, 4'h0));
    // counter runs, then a write clears it
    axi_wr(pwm_pkg::IDX_CTRL, 8'h00, OK);
    axi_wr(pwm_pkg::IDX_EN, 8'h04, OK);
    tick(20);
    axi_rd(pwm_pkg::IDX_CNT0 + 8'h02, OK);
    check_val(32'(got != 32'h0000_0000), 32'h0000_0001);
    axi_wr(pwm_pkg::IDX_EN, 8'h00, OK);
    axi_wr(pwm_pkg::IDX_CNT0 + 8'h02, 8'($urandom), OK);
    axi_rd(pwm_pkg::IDX_CNT0 + 8'h02, OK);
    check_val(got, 32'h0000_0000);
    // clock tree: prescaled and scaled clocks counted side by side
    axi_wr(pwm_pkg::IDX_ALIGN, 8'h00, OK);
    axi_wr(pwm_pkg::IDX_PER0, 8'hFF, OK);
    axi_wr(pwm_pkg::IDX_PER0 + 8'h02, 8'hFF, OK);
    for (int i = 0; i < 4; i++) begin
      axi_wr(pwm_pkg::IDX_CNT0 + 8'(i), 8'($urandom), OK);
    end
    axi_wr(pwm_pkg::IDX_CTRL, 8'((SEL_B << 3) | SEL_A), OK);
    axi_wr(pwm_pkg::IDX_POL, 8'hA0, OK); // channels 1 and 3 on scaled clocks
    axi_wr(pwm_pkg::IDX_SCALE_A, 8'(SCL_A), OK);
    axi_wr(pwm_pkg::IDX_SCALE_B, 8'(SCL_B), OK);
    axi_wr(pwm_pkg::IDX_EN, 8'h0F, OK);
    // enable lands two edges into its write, disable likewise
    tick(RUN_EDGES - 4);
    axi_wr(pwm_pkg::IDX_EN, 8'h00, OK);
    for (int i = 0; i < 4; i++) begin
      axi_rd(pwm_pkg::IDX_CNT0 + 8'(i), OK);
      check_val(got, cnt_exp(i));
    end
    finish_test();
  end
endmodule : pwm_core_tb_top
